// >>> inc/pdc_pkg.sv
// Constants and carrier types of the parameter data set interpreter.
// Assumes users write pdc_pkg::name; nothing is imported.
package pdc_pkg;

    // ************************************************************
    // Data set and request codes
    // ************************************************************
    localparam logic [7:0] PDC_DS_INDEX = 8'h2F;
    localparam logic [7:0] PDC_REQ_READ = 8'h01;
    localparam logic [7:0] PDC_REQ_CHANGE = 8'h02;
    localparam logic [7:0] PDC_REQ_VENDOR = 8'h40;
    localparam logic [7:0] PDC_RSP_READ_NEG = 8'h81;
    localparam logic [7:0] PDC_RSP_CHANGE_NEG = 8'h82;
    localparam logic [7:0] PDC_RSP_VENDOR_NEG = 8'hC0;
    localparam logic [7:0] PDC_ATTR_VALUE = 8'h10;
    localparam logic [3:0] PDC_SVC_NONE = 4'h0;
    localparam logic [3:0] PDC_SVC_READ = 4'h1;
    localparam logic [3:0] PDC_SVC_WRITE = 4'h2;
    localparam logic [3:0] PDC_SVC_WRITE_VOL = 4'h3;

    // ************************************************************
    // Field limits, formats and error values
    // ************************************************************
    localparam logic [7:0] PDC_PCOUNT_MIN = 8'h01;
    localparam logic [7:0] PDC_PCOUNT_MAX = 8'h13;
    localparam logic [7:0] PDC_ELEM_MAX = 8'h75;
    localparam logic [7:0] PDC_FMT_DWORD = 8'h43;
    localparam logic [7:0] PDC_FMT_ERROR = 8'h44;
    localparam logic [7:0] PDC_VALUES_ONE = 8'h01;
    localparam logic [15:0] PDC_ERR_VENDOR_BASE = 16'h0080;
    localparam logic [15:0] PDC_ERR_BAD_REQUEST = 16'h0016;
    localparam logic [15:0] PDC_ERR_BAD_ATTR = 16'h0017;
    localparam logic [15:0] PDC_ERR_BAD_COUNT = 16'h0018;
    localparam logic [15:0] PDC_ERR_BAD_SERVICE = 16'h0100;
    localparam logic [7:0] PDC_ERR1_STATE_CONFLICT = 8'hB5;
    localparam logic [7:0] PDC_ERR1_BAD_INDEX = 8'hB0;
    localparam logic [7:0] PDC_ERR1_NONE = 8'h00;
    localparam int PDC_NUM_CONN = 3;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic [7:0] ref_num;
        logic [7:0] req_id;
        logic [7:0] axis;
        logic [7:0] param_count;
        logic [7:0] attribute;
        logic [7:0] elem_count;
        logic [15:0] param_num;
        logic [15:0] subindex;
        logic [31:0] value;
    } pdc_order_type;

    typedef struct packed {
        logic [7:0] ref_num;
        logic [7:0] resp_id;
        logic [7:0] axis;
        logic [7:0] param_count;
        logic [7:0] format;
        logic [7:0] num_values;
        logic [31:0] value;
    } pdc_resp_type;

    typedef struct packed {
        logic [7:0] axis;
        logic local_gw;
        logic profile;
        logic write;
        logic [3:0] service;
        logic [7:0] elem_count;
        logic [15:0] param_num;
        logic [15:0] subindex;
        logic [31:0] value;
    } pdc_exec_type;

    typedef struct packed {
        logic ok;
        logic profile;
        logic write;
        logic [3:0] service;
        logic [7:0] pos_id;
        logic [7:0] neg_id;
        logic [15:0] err;
    } pdc_check_type;

    typedef enum logic [1:0] {PDC_IDLE, PDC_EXEC, PDC_WRITE} pdc_fsm_type;
    typedef enum logic [1:0] {PDC_RD_OK, PDC_RD_BUSY, PDC_RD_BADIDX} pdc_rd_kind_type;

endpackage

// >>> verilog/pdc_order_check.sv
// Field check and identifier decode of one stored parameter order.
// Assumes a stable order while the result is used.
`timescale 1ns/10ps
module pdc_order_check (
    input wire pdc_pkg::pdc_order_type i_order,
    output pdc_pkg::pdc_check_type o_check
);

    // ************************************************************
    // Decode and field limits
    // ************************************************************
    always_comb begin
        o_check = '0;
        o_check.ok = 1'b1;
        o_check.service = i_order.attribute[7:4];
        case (i_order.req_id)
            pdc_pkg::PDC_REQ_READ: begin
                o_check.profile = 1'b1;
                o_check.pos_id = pdc_pkg::PDC_REQ_READ;
                o_check.neg_id = pdc_pkg::PDC_RSP_READ_NEG;
            end
            pdc_pkg::PDC_REQ_CHANGE: begin
                o_check.profile = 1'b1;
                o_check.write = 1'b1;
                o_check.pos_id = pdc_pkg::PDC_REQ_CHANGE;
                o_check.neg_id = pdc_pkg::PDC_RSP_CHANGE_NEG;
            end
            pdc_pkg::PDC_REQ_VENDOR: begin
                o_check.pos_id = pdc_pkg::PDC_REQ_VENDOR;
                o_check.neg_id = pdc_pkg::PDC_RSP_VENDOR_NEG;
                o_check.write = (o_check.service == pdc_pkg::PDC_SVC_WRITE) ||
                    (o_check.service == pdc_pkg::PDC_SVC_WRITE_VOL);
            end
            default: begin
                // Unknown identifier answered as a failed profile read
                o_check.ok = 1'b0;
                o_check.profile = 1'b1;
                o_check.neg_id = pdc_pkg::PDC_RSP_READ_NEG;
                o_check.err = pdc_pkg::PDC_ERR_BAD_REQUEST;
            end
        endcase
        if (o_check.ok) begin
            if (i_order.param_count < pdc_pkg::PDC_PCOUNT_MIN ||
                i_order.param_count > pdc_pkg::PDC_PCOUNT_MAX ||
                i_order.elem_count > pdc_pkg::PDC_ELEM_MAX) begin
                o_check.ok = 1'b0;
                o_check.err = pdc_pkg::PDC_ERR_BAD_COUNT;
            end else if (o_check.profile && (i_order.attribute != pdc_pkg::PDC_ATTR_VALUE ||
                         i_order.param_count != pdc_pkg::PDC_PCOUNT_MIN)) begin
                o_check.ok = 1'b0;
                o_check.err = pdc_pkg::PDC_ERR_BAD_ATTR;
            end else if (!o_check.profile && o_check.service > pdc_pkg::PDC_SVC_WRITE_VOL) begin
                o_check.ok = 1'b0;
                o_check.err = pdc_pkg::PDC_ERR_BAD_SERVICE;
            end
        end
    end

endmodule

// >>> verilog/pdc_resp_mem.sv
// Small response store, one word per master connection.
// Assumes one writer; read data come from a register a cycle later.
`timescale 1ns/10ps
module pdc_resp_mem #(
    parameter int WIDTH = 80,
    parameter int DEPTH = 3,
    parameter int AW = 2
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rdata;
    } pdc_mem_state_type;

    pdc_mem_state_type s_q;
    pdc_mem_state_type s_d;

    // ************************************************************
    // Storage
    // ************************************************************
    // Out-of-range addresses read zero rather than unknown
    always_comb begin
        s_d = s_q;
        if (i_we && {1'b0, i_waddr} < (AW+1)'(DEPTH)) begin
            s_d.mem[i_waddr] = i_wdata;
        end
        s_d.rdata = ({1'b0, i_raddr} < (AW+1)'(DEPTH)) ? s_q.mem[i_raddr] : '0;
    end

    // Register the copy
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;

endmodule

// >>> verilog/pdc_param_channel.sv
// Parameter data set interpreter: stores orders, runs them in turn,
// answers data set reads.
// Assumes all ports on i_sys_clk; none is synchronised.
// Connection 0 is class 1, the others class 2.
//
// What this block does
// - Orders and responses only through data set 47
// - Decode request identifier read, change, vendor
// - Positive response echoes the request identifier
// - Negative identifiers 0x81, 0x82, 0xC0
// - Axis byte selects target unit, 0 to 255
// - Axis zero targets the gateway itself
// - Nonzero axis forwards to that bus address
// - Parameter count limited to 1 through 19
// - Attribute decode for vendor and profile
// - Element count 0 non-indexed, up to 117
// - Parameter number selects the accessed parameter
// - Profile: single double word, formats 0x43/0x44
// - Error value: profile codes or 0x0080 plus code
// - Order arrives by write, processed afterwards
// - After processing, read returns latest order's response
// - Early read answers negatively with code 0xB5
// - Same mechanism for class 1 and class 2
// - Response reference copies request reference
// - Attribute upper nibble is the vendor service
// - Two class 2 connections beside class 1
`timescale 1ns/10ps
module pdc_param_channel #(
    parameter int NUM_CONN = pdc_pkg::PDC_NUM_CONN,
    parameter int CW = 2
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_wr_req,
    input wire logic [CW-1:0] i_wr_conn,
    input wire logic [7:0] i_wr_index,
    input wire pdc_pkg::pdc_order_type i_wr_order,
    output logic o_wr_ack,
    output logic o_wr_accepted,
    input wire logic i_rd_req,
    input wire logic [CW-1:0] i_rd_conn,
    input wire logic [7:0] i_rd_index,
    output logic o_rd_ack,
    output logic o_rd_ok,
    output logic [7:0] o_rd_err_code1,
    output pdc_pkg::pdc_resp_type o_rd_resp,
    output logic o_exec_req,
    output pdc_pkg::pdc_exec_type o_exec_cmd,
    input wire logic i_exec_done,
    input wire logic i_exec_ok,
    input wire logic [31:0] i_exec_value,
    input wire logic [15:0] i_exec_err,
    output logic o_busy
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic wr_ack;
        logic wr_accepted;
        logic rd_stage;
        pdc_pkg::pdc_rd_kind_type rd_kind;
        logic rd_ack;
        logic rd_ok;
        logic [7:0] rd_code1;
        pdc_pkg::pdc_resp_type rd_resp;
        logic [NUM_CONN-1:0] has_order;
        logic [NUM_CONN-1:0] pending;
        pdc_pkg::pdc_order_type [NUM_CONN-1:0] orders;
        pdc_pkg::pdc_fsm_type fsm;
        logic [CW-1:0] cur_conn;
        logic redo;
        logic exec_req;
        pdc_pkg::pdc_exec_type exec_cmd;
        logic mem_we;
        logic [CW-1:0] mem_waddr;
        pdc_pkg::pdc_resp_type mem_wdata;
        logic busy;
    } pdc_state_type;

    pdc_state_type s_q;
    pdc_state_type s_d;

    logic wr_take;
    logic rd_conn_ok;
    logic [NUM_CONN-1:0] wr_hit;
    logic pick_valid;
    logic [CW-1:0] pick_idx;
    logic [CW-1:0] sel_idx;
    pdc_pkg::pdc_order_type sel_order;
    pdc_pkg::pdc_check_type sel_chk;
    pdc_pkg::pdc_resp_type mem_rdata;

    // ************************************************************
    // Request acceptance
    // ************************************************************
    // Other data sets and connections are not stored
    assign wr_take = i_wr_req && (i_wr_index == pdc_pkg::PDC_DS_INDEX) &&
        ({1'b0, i_wr_conn} < (CW+1)'(NUM_CONN));
    assign rd_conn_ok = ({1'b0, i_rd_conn} < (CW+1)'(NUM_CONN));

    // One write decode per connection, class 1 and class 2 alike
    genvar gc;
    generate
        for (gc = 0; gc < NUM_CONN; gc++) begin : g_conn
            assign wr_hit[gc] = wr_take && (i_wr_conn == CW'(gc));
        end
    endgenerate

    // ************************************************************
    // Scheduler pick
    // ************************************************************
    // Lowest pending connection first; one rewritten this cycle
    // waits a cycle so that its newest order is executed
    always_comb begin
        pick_valid = 1'b0;
        pick_idx = '0;
        for (int c = NUM_CONN - 1; c >= 0; c--) begin
            if (s_q.pending[c] && !wr_hit[c]) begin
                pick_valid = 1'b1;
                pick_idx = CW'(c);
            end
        end
    end

    assign sel_idx = (s_q.fsm == pdc_pkg::PDC_IDLE) ? pick_idx : s_q.cur_conn;
    assign sel_order = s_q.orders[sel_idx];

    pdc_order_check u_check (
        .i_order(sel_order),
        .o_check(sel_chk)
    );

    // ************************************************************
    // Response store
    // ************************************************************
    pdc_resp_mem #(
        .WIDTH($bits(pdc_pkg::pdc_resp_type)),
        .DEPTH(NUM_CONN),
        .AW(CW)
    ) u_mem (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_we(s_q.mem_we),
        .i_waddr(s_q.mem_waddr),
        .i_wdata(s_q.mem_wdata),
        .i_raddr(i_rd_conn),
        .o_rdata(mem_rdata)
    );

    // Response word for one finished or refused order
    function automatic pdc_pkg::pdc_resp_type build_resp(
        input pdc_pkg::pdc_order_type ord,
        input pdc_pkg::pdc_check_type chk,
        input logic ok,
        input logic [31:0] value,
        input logic [15:0] err
    );
        pdc_pkg::pdc_resp_type r;
        r = '0;
        r.ref_num = ord.ref_num;
        r.axis = ord.axis;
        r.param_count = ord.param_count;
        if (ok) begin
            r.resp_id = chk.pos_id;
            r.format = pdc_pkg::PDC_FMT_DWORD;
            r.num_values = chk.write ? '0 : pdc_pkg::PDC_VALUES_ONE;
            r.value = chk.write ? '0 : value;
        end else begin
            r.resp_id = chk.neg_id;
            r.format = pdc_pkg::PDC_FMT_ERROR;
            r.num_values = pdc_pkg::PDC_VALUES_ONE;
            r.value = {16'h0000, err};
        end
        return r;
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.wr_ack = i_wr_req;
        s_d.wr_accepted = wr_take;
        s_d.mem_we = 1'b0;

        // Read stage 0: classify on state before this edge's write
        s_d.rd_stage = i_rd_req;
        if (i_rd_index != pdc_pkg::PDC_DS_INDEX || !rd_conn_ok) begin
            s_d.rd_kind = pdc_pkg::PDC_RD_BADIDX;
        end else if (s_q.pending[i_rd_conn] || !s_q.has_order[i_rd_conn]) begin
            s_d.rd_kind = pdc_pkg::PDC_RD_BUSY;
        end else begin
            s_d.rd_kind = pdc_pkg::PDC_RD_OK;
        end

        // Read stage 1: stored response is ready in the memory register
        s_d.rd_ack = s_q.rd_stage;
        s_d.rd_ok = s_q.rd_stage && (s_q.rd_kind == pdc_pkg::PDC_RD_OK);
        s_d.rd_resp = s_d.rd_ok ? mem_rdata : '0;
        if (!s_q.rd_stage || s_q.rd_kind == pdc_pkg::PDC_RD_OK) begin
            s_d.rd_code1 = pdc_pkg::PDC_ERR1_NONE;
        end else if (s_q.rd_kind == pdc_pkg::PDC_RD_BUSY) begin
            s_d.rd_code1 = pdc_pkg::PDC_ERR1_STATE_CONFLICT;
        end else begin
            s_d.rd_code1 = pdc_pkg::PDC_ERR1_BAD_INDEX;
        end

        // Memory takes the response at this edge: order done
        if (s_q.mem_we) begin
            s_d.pending[s_q.mem_waddr] = 1'b0;
        end

        // New orders; placed after the clear so a new order is never lost
        for (int c = 0; c < NUM_CONN; c++) begin
            if (wr_hit[c]) begin
                s_d.orders[c] = i_wr_order;
                s_d.pending[c] = 1'b1;
                s_d.has_order[c] = 1'b1;
            end
        end

        case (s_q.fsm)
            pdc_pkg::PDC_IDLE: begin
                if (pick_valid) begin
                    s_d.cur_conn = pick_idx;
                    s_d.redo = 1'b0;
                    if (sel_chk.ok) begin
                        s_d.exec_req = 1'b1;
                        s_d.exec_cmd.axis = sel_order.axis;
                        s_d.exec_cmd.local_gw = (sel_order.axis == 8'h00);
                        s_d.exec_cmd.profile = sel_chk.profile;
                        s_d.exec_cmd.write = sel_chk.write;
                        s_d.exec_cmd.service = sel_chk.service;
                        s_d.exec_cmd.elem_count = sel_order.elem_count;
                        s_d.exec_cmd.param_num = sel_order.param_num;
                        s_d.exec_cmd.subindex = sel_order.subindex;
                        s_d.exec_cmd.value = sel_order.value;
                        s_d.fsm = pdc_pkg::PDC_EXEC;
                    end else begin
                        // Refused orders never reach the executor
                        s_d.mem_we = 1'b1;
                        s_d.mem_waddr = pick_idx;
                        s_d.mem_wdata = build_resp(sel_order, sel_chk, 1'b0, '0, sel_chk.err);
                        s_d.fsm = pdc_pkg::PDC_WRITE;
                    end
                end
            end
            pdc_pkg::PDC_EXEC: begin
                if (wr_hit[s_q.cur_conn]) begin
                    s_d.redo = 1'b1;
                end
                if (i_exec_done) begin
                    s_d.exec_req = 1'b0;
                    if (s_q.redo || wr_hit[s_q.cur_conn]) begin
                        // Result of a superseded order is dropped
                        s_d.fsm = pdc_pkg::PDC_IDLE;
                    end else begin
                        s_d.mem_we = 1'b1;
                        s_d.mem_waddr = s_q.cur_conn;
                        s_d.mem_wdata = build_resp(sel_order, sel_chk, i_exec_ok, i_exec_value,
                            sel_chk.profile ? pdc_pkg::PDC_ERR_VENDOR_BASE + {8'h00, i_exec_err[7:0]}
                                            : i_exec_err);
                        s_d.fsm = pdc_pkg::PDC_WRITE;
                    end
                end
            end
            pdc_pkg::PDC_WRITE: begin
                s_d.fsm = pdc_pkg::PDC_IDLE;
            end
            default: begin
                s_d.fsm = pdc_pkg::PDC_IDLE;
                s_d.exec_req = 1'b0;
            end
        endcase
        s_d.busy = (s_d.fsm != pdc_pkg::PDC_IDLE) || (s_d.pending != '0);
    end

    // ************************************************************
    // Register the copy
    // ************************************************************
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs, all from flip-flops
    // ************************************************************
    assign o_wr_ack = s_q.wr_ack;
    assign o_wr_accepted = s_q.wr_accepted;
    assign o_rd_ack = s_q.rd_ack;
    assign o_rd_ok = s_q.rd_ok;
    assign o_rd_err_code1 = s_q.rd_code1;
    assign o_rd_resp = s_q.rd_resp;
    assign o_exec_req = s_q.exec_req;
    assign o_exec_cmd = s_q.exec_cmd;
    assign o_busy = s_q.busy;

endmodule

// >>> tb/pdc_exec_model.sv
// Executor partner: answers each order after a set delay.
// Assumes the block holds its request and command until the done pulse.
`timescale 1ns/10ps
module pdc_exec_model (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_req,
    input wire pdc_pkg::pdc_exec_type i_cmd,
    input wire logic [7:0] i_delay,
    input wire logic i_fail,
    output logic o_done,
    output logic o_ok,
    output logic [31:0] o_value,
    output logic [15:0] o_err
);
    logic [7:0] cnt_q;
    logic done_q;
    logic [31:0] val;
    logic [15:0] err;
    // Result tied to target unit and parameter number
    assign val = {i_cmd.param_num, 8'hA5, i_cmd.axis};
    assign err = {8'h3C, i_cmd.param_num[7:0]};
    // Inverted data outside the pulse, so stale values never match
    assign o_done = done_q;
    assign o_ok = done_q ? !i_fail : i_fail;
    assign o_value = done_q ? val : ~val;
    assign o_err = done_q ? err : ~err;
    // Processing time counted from the request, one pulse per order
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_q <= 8'h00;
            done_q <= 1'b0;
        end else begin
            done_q <= i_req && !done_q && cnt_q == i_delay;
            cnt_q <= (i_req && !done_q) ? cnt_q + 8'h01 : 8'h00;
        end
    end
endmodule

// >>> tb/pdc_param_channel_checker.sv
// Port assertions of the parameter data set interpreter.
// Assumes a bind to pdc_param_channel; one clock, async low reset.
`timescale 1ns/10ps
module pdc_checker (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_wr_req,
    input wire logic [7:0] i_wr_index,
    input wire logic o_wr_ack,
    input wire logic o_wr_accepted,
    input wire logic i_rd_req,
    input wire logic [7:0] i_rd_index,
    input wire logic o_rd_ack,
    input wire logic o_rd_ok,
    input wire logic [7:0] o_rd_err_code1,
    input wire pdc_pkg::pdc_resp_type o_rd_resp,
    input wire logic o_exec_req,
    input wire pdc_pkg::pdc_exec_type o_exec_cmd,
    input wire logic i_exec_done,
    input wire logic o_busy
);
    // ************************************************************
    // Handshake and answer timing
    // ************************************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    wr_ack_a: assert property (i_wr_req |=> o_wr_ack) else $error("write not acked");
    wr_index_a: assert property (i_wr_req && i_wr_index != 8'h2F |=> !o_wr_accepted) else $error("bad index kept");
    rd_ack_a: assert property (i_rd_req |-> ##2 o_rd_ack) else $error("read not answered");
    rd_index_a: assert property (i_rd_req && i_rd_index != 8'h2F |-> ##2 !o_rd_ok && o_rd_err_code1 == 8'hB0)
        else $error("bad index read");
    rd_neg_a: assert property (o_rd_ack && !o_rd_ok |-> o_rd_resp == '0 && o_rd_err_code1 != 8'h00)
        else $error("negative read malformed");
    exec_hold_a: assert property (o_exec_req && !i_exec_done |=> o_exec_req && $stable(o_exec_cmd))
        else $error("command dropped early");
    exec_end_a: assert property (o_exec_req && i_exec_done |=> !o_exec_req) else $error("request held");
    local_gw_a: assert property (o_exec_req |-> o_exec_cmd.local_gw == (o_exec_cmd.axis == 8'h00))
        else $error("wrong target");
    exec_busy_a: assert property (o_exec_req |-> o_busy) else $error("busy low");
    cover property (o_rd_ack && o_rd_ok);
    cover property (o_rd_ack && o_rd_err_code1 == 8'hB5);
    cover property (o_exec_req && i_exec_done);
endmodule
bind pdc_param_channel pdc_checker u_chk (.i_sys_clk, .i_reset_n, .i_wr_req,
    .i_wr_index, .o_wr_ack, .o_wr_accepted, .i_rd_req, .i_rd_index, .o_rd_ack, .o_rd_ok, .o_rd_err_code1,
    .o_rd_resp, .o_exec_req, .o_exec_cmd, .i_exec_done, .o_busy);

// >>> tb/tb_top.sv
// Self-checking bench for the parameter data set interpreter.
// Assumes the executor model and the bound checker.
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rr = 1'b0, fail = 1'b0;
    logic wack, wacc, rack, rok, xreq, done, ok, busy;
    logic [1:0] wc = 2'd0, rc = 2'd0;
    logic [7:0] wi = 8'h2F, ri = 8'h2F, dly = 8'h03, rerr, code;
    logic [31:0] val;
    logic [15:0] xerr;
    pdc_pkg::pdc_order_type wo = '0;
    pdc_pkg::pdc_resp_type resp, got;
    pdc_pkg::pdc_exec_type cmd;
    int err_total = 0, checked = 0;
    always #2 clk = ~clk;
    pdc_param_channel DUT (.i_sys_clk(clk), .i_reset_n(rst_n), .i_wr_req(wr), .i_wr_conn(wc), .i_wr_index(wi),
        .i_wr_order(wo), .o_wr_ack(wack), .o_wr_accepted(wacc), .i_rd_req(rr), .i_rd_conn(rc), .i_rd_index(ri),
        .o_rd_ack(rack), .o_rd_ok(rok), .o_rd_err_code1(rerr), .o_rd_resp(resp), .o_exec_req(xreq),
        .o_exec_cmd(cmd), .i_exec_done(done), .i_exec_ok(ok), .i_exec_value(val), .i_exec_err(xerr), .o_busy(busy));
    pdc_exec_model u_exec (.i_sys_clk(clk), .i_reset_n(rst_n), .i_req(xreq), .i_cmd(cmd), .i_delay(dly),
        .i_fail(fail), .o_done(done), .o_ok(ok), .o_value(val), .o_err(xerr));
    // ************************************************************
    // Shared drivers and comparisons
    // ************************************************************
    task automatic report_and_stop;
        $display("mismatches %0d, comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [87:0] g, e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    function automatic pdc_pkg::pdc_order_type mk(input logic [7:0] f, i, a, p, t, m, input logic [15:0] n);
        mk = {f, i, a, p, t, m, n, 16'h0000, 32'h1234_5678};
    endfunction
    // Expected response; rd marks value-returning services
    function automatic pdc_pkg::pdc_resp_type ex(input pdc_pkg::pdc_order_type o, input logic k, input logic [15:0] e);
        logic rd;
        rd = o.req_id == 8'h01 || (o.req_id == 8'h40 && o.attribute[7:4] == 4'h1);
        ex = {o.ref_num, 8'h00, o.axis, o.param_count, 8'h44, 8'h01, 16'h0000, e};
        if (k) ex.value = rd ? {o.param_num, 8'hA5, o.axis} : 32'h0000_0000;
        if (k) ex.num_values = {7'h00, rd};
        if (k) ex.format = 8'h43;
        ex.resp_id = k ? o.req_id : (o.req_id == 8'h02 ? 8'h82 : (o.req_id == 8'h40 ? 8'hC0 : 8'h81));
    endfunction
    task automatic put(input logic [1:0] c, input logic [7:0] x, input pdc_pkg::pdc_order_type o, input logic [1:0] ea);
        @(posedge clk);
        wr <= 1'b1;
        wc <= c;
        wi <= x;
        wo <= o;
        @(posedge clk);
        wr <= 1'b0;
        #1 chk({wack, wacc}, ea);
    endtask
    task automatic get(input logic [1:0] c, input logic [7:0] x);
        @(posedge clk);
        rr <= 1'b1;
        rc <= c;
        ri <= x;
        @(posedge clk);
        rr <= 1'b0;
        @(posedge clk);
        #1 got = resp;
        code = rerr;
        chk(rack, 1'b1);
    endtask
    // Reads repeated while busy; bound exhausted ends the run
    task automatic poll(input logic [1:0] c, input pdc_pkg::pdc_resp_type e);
        for (int n = 0; n < 40 && (n == 0 || rok !== 1'b1); n++) get(c, 8'h2F);
        if (rok !== 1'b1) begin
            err_total++;
            report_and_stop();
        end else chk({code, got}, {8'h00, e});
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_early;
        put(2'd0, 8'h30, mk(8'h01, 8'h01, 8'h00, 8'h01, 8'h10, 8'h00, 16'h0001), 2'b10);
        get(2'd0, 8'h2F);
        chk({rok, code}, 9'h0B5);
        get(2'd1, 8'h30);
        chk({rok, code}, 9'h0B0);
    endtask
    task automatic t_exec;
        pdc_pkg::pdc_order_type o;
        logic [7:0] ids [3] = '{8'h01, 8'h02, 8'h40};
        dly = 8'h0C;
        for (logic [1:0] f = 0; f < 2; f++) begin
            for (logic [7:0] j = 0; j < 3; j++) begin
                o = mk(8'h10 + j, ids[j], j * 8'h03, 8'h01, 8'h10, 8'h00, 16'h206C + j);
                fail = f[0];
                put(2'd0, 8'h2F, o, 2'b11);
                get(2'd0, 8'h2F);
                chk({rok, code}, 9'h0B5);
                poll(2'd0, ex(o, !f[0], j == 2 ? {8'h3C, o.param_num[7:0]} : 16'h0080 + o.param_num[7:0]));
            end
        end
        fail = 1'b0;
    endtask
    task automatic t_vendor;
        pdc_pkg::pdc_order_type o;
        for (logic [7:0] s = 8'h20; s < 8'h40; s += 8'h10) begin
            o = mk(s, 8'h40, 8'h05, 8'h13, s, 8'h75, 16'h2AF8);
            put(2'd2, 8'h2F, o, 2'b11);
            poll(2'd2, ex(o, 1'b1, 16'h0000));
        end
    endtask
    task automatic t_bad;
        pdc_pkg::pdc_order_type o;
        logic [47:0] tb [6] = '{48'h0701_1000_0016, 48'h4014_1000_0018, 48'h4000_1000_0018, 48'h0101_1076_0018,
            48'h0201_2000_0017, 48'h4001_4000_0100};
        for (int k = 0; k < 6; k++) begin
            o = mk(8'h60, tb[k][47:40], 8'h02, tb[k][39:32], tb[k][31:24], tb[k][23:16], 16'h0042);
            put(2'd1, 8'h2F, o, 2'b11);
            poll(2'd1, ex(o, 1'b0, tb[k][15:0]));
        end
    endtask
    task automatic t_conns;
        pdc_pkg::pdc_order_type a, b;
        dly = 8'h00;
        a = mk(8'hA1, 8'h40, 8'h07, 8'h01, 8'h10, 8'h00, 16'h1111);
        b = mk(8'hB2, 8'h01, 8'h09, 8'h01, 8'h10, 8'h00, 16'h2222);
        put(2'd1, 8'h2F, a, 2'b11);
        put(2'd2, 8'h2F, b, 2'b11);
        poll(2'd2, ex(b, 1'b1, 16'h0000));
        poll(2'd1, ex(a, 1'b1, 16'h0000));
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_early();
        t_exec();
        t_vendor();
        t_bad();
        t_conns();
        report_and_stop();
    end
endmodule
